/* File: tb/cfgst_host_mdl.sv */
// host model that watches and may hold the init pin
`timescale 1ns/1ps
module cfgst_host_mdl (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic hold_i, // host pulls init low
  input wire logic dev_oe_i, // device drives init
  input wire logic dev_out_i, // device init value
  input wire logic load_en_i, // device takes data
  output logic init_o, // resolved init wire
  output logic abort_o // init seen low any time after load enable was first seen
);
  logic seen_r;
  // open drain with pull-up, low if anyone pulls
  assign init_o = !(hold_i || (dev_oe_i && !dev_out_i));
  // data only after init high, abort once it falls
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      seen_r <= seen_r || load_en_i;
      abort_o <= abort_o || (seen_r && !init_o);
    end
  end
endmodule

/* File: tb/cfgst_top_chk.sv */
// checker on the status pin block ports
`timescale 1ns/1ps
module cfgst_top_chk (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic master_mode_i, // master
  input wire logic data_error_i, // error
  input wire logic init_in_i, // init wire
  input wire logic init_out_o, // init value
  input wire logic init_oe_o, // init enable
  input wire logic user_init_out_i, // user init
  input wire logic user_init_oe_i, // user enable
  input wire logic cfg_busy_high_out_o, // busy high
  input wire logic cfg_busy_low_out_o, // busy low
  input wire cfgst_pkg::cfgst_scan_t scan_pad_i, // pads
  input wire cfgst_pkg::cfgst_scan_t scan_core_o, // to test logic
  input wire logic load_enable_o, // loading
  input wire logic user_active_o // user mode
);
  import cfgst_pkg::*;
  // ****
  // pin checks
  // ****
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  busy_high_a: assert property (!user_active_o |-> cfg_busy_high_out_o)
    else $error("busy high lost");
  busy_low_a: assert property (!user_active_o |-> !cfg_busy_low_out_o)
    else $error("busy low lost");
  clear_low_a: assert property ($fell(rst_i) |-> (init_oe_o && !init_out_o) [*3])
    else $error("init not low in clear");
  wait_hold_a: assert property (!load_enable_o && !user_active_o && !init_in_i
    |=> !load_enable_o) else $error("load began with init low");
  master_wait_a: assert property (master_mode_i && $rose(init_in_i) && !user_active_o
    |=> !load_enable_o [*7]) else $error("master wait too short");
  error_hold_a: assert property (load_enable_o && data_error_i
    |=> (init_oe_o && !init_out_o) [*4]) else $error("error not flagged");
  user_init_a: assert property (user_active_o |-> init_oe_o == $past(user_init_oe_i)
    && init_out_o == $past(user_init_out_i)) else $error("init not handed to user");
  scan_core_a: assert property (!$past(rst_i) |-> scan_core_o == $past(scan_pad_i))
    else $error("scan path not from pads");
  cover property ($rose(user_active_o));
  cover property (load_enable_o && data_error_i);
  cover property (master_mode_i && $rose(load_enable_o));
endmodule

/* File: tb/tb_top.sv */
// bench for the configuration status pin logic
`timescale 1ns/1ps
module tb_top;
  import cfgst_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, hold = 1'b1, master_mode_i = 1'b0;
  logic scan_keep_primitive_i = 1'b0, data_error_i = 1'b0, load_done_i = 1'b0;
  logic user_init_out_i = 1'b1, user_init_oe_i = 1'b1, user_hi_out_i = 1'b0, user_lo_out_i = 1'b1;
  logic init_in_i, init_out_o, init_oe_o, cfg_busy_high_out_o, cfg_busy_low_out_o;
  logic scan_enable_o, load_enable_o, user_active_o, abort;
  cfgst_scan_t scan_pad_i = 3'h5, scan_core_o, scan_user_o;
  int n_errors = 0, samples_checked = 0, k;
  cfgst_top #(.CLEAR_CYC(4), .WAIT_CYC(8)) i_cfgst_top (.*);
  cfgst_host_mdl i_cfgst_host_mdl (.clock_i, .rst_i, .hold_i(hold), .dev_oe_i(init_oe_o),
    .dev_out_i(init_out_o), .load_en_i(load_enable_o), .init_o(init_in_i), .abort_o(abort));
  // clock, 40 ns period
  initial forever #20 clock_i = ~clock_i;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("errors=%0d checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reset with the host holding init low, check clearing and the wait
  task reset_dev(input logic m);
    rst_i = 1'b1;
    master_mode_i = m;
    load_done_i = 1'b0;
    data_error_i = 1'b0;
    hold = 1'b1;
    repeat (10) @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    chk(init_oe_o, 1'b1);
    repeat (20) @(negedge clock_i);
    chk({init_oe_o, load_enable_o, cfg_busy_high_out_o, cfg_busy_low_out_o}, 8'h2);
  endtask
  // free init and time the load start, master adds its extra wait
  task release_init(input logic m);
    hold = 1'b0;
    for (k = 0; k < 20 && load_enable_o !== 1'b1; k++) @(negedge clock_i);
    chk(k >= (m ? 8 : 1) && k <= (m ? 11 : 2), 1'b1);
  endtask
  // full start up to the load window
  task start(input logic m);
    reset_dev(m);
    release_init(m);
  endtask
  // master: init pulled low again mid wait restarts the count
  task run_rehold;
    reset_dev(1'b1);
    hold = 1'b0;
    repeat (4) @(negedge clock_i);
    hold = 1'b1;
    repeat (3) @(negedge clock_i);
    chk(load_enable_o, 1'b0);
    release_init(1'b1);
  endtask
  // finish loading, pins go to user
  task run_user(input logic keep);
    start(1'b0);
    scan_keep_primitive_i = keep;
    user_hi_out_i = keep;
    user_lo_out_i = !keep;
    user_init_out_i = !keep;
    load_done_i = 1'b1;
    scan_pad_i = 3'h6;
    repeat (3) @(negedge clock_i);
    chk({user_active_o, cfg_busy_high_out_o, cfg_busy_low_out_o}, {1'b1, keep, !keep});
    chk({init_oe_o, init_out_o}, {1'b1, !keep});
    chk({scan_enable_o, scan_user_o, scan_core_o}, {keep, keep ? 3'h0 : 3'h6, 3'h6});
  endtask
  // data error mid load, later done is ignored
  task run_error;
    start(1'b0);
    data_error_i = 1'b1;
    repeat (2) @(negedge clock_i);
    load_done_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk({init_oe_o, init_out_o, abort, user_active_o, load_enable_o}, 8'h14);
  endtask
  // main sequence
  initial begin
    run_user(1'b0);
    run_user(1'b1);
    run_error;
    start(1'b1);
    run_rehold;
    complete_run;
  end
  // watchdog
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
endmodule
bind cfgst_top cfgst_top_chk i_cfgst_top_chk (.*);

/* File: verilog/cfgst_delay.sv */
// counter that times the extra wait after the init pin rises
`timescale 1ns/1ps
`include "cfgst_regs.svh"
module cfgst_delay #(
  parameter int CNT_W = `CFGST_CNT_W
) (
  input wire logic clock_i, // clock
  input wire logic rst_i, // async reset, active high
  input wire logic start_i, // restart the count
  input wire logic run_i, // count while high
  input wire logic [CNT_W-1:0] limit_i, // count that ends the wait, done follows one cycle later
  output logic done_o // wait elapsed
);
  logic [CNT_W-1:0] cnt_r;

  // count up while running, restart on start
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (start_i) begin
      cnt_r <= '0;
    end else if (run_i && cnt_r != limit_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // done once the limit is reached
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= run_i && !start_i && (cnt_r == limit_i);
    end
  end
endmodule

/* File: verilog/cfgst_pkg.sv */
// types for the configuration status pin logic
package cfgst_pkg;
  typedef enum logic [2:0] {
    CFGST_POWER,
    CFGST_CLEAR,
    CFGST_WAIT,
    CFGST_DELAY,
    CFGST_LOAD,
    CFGST_ERROR,
    CFGST_USER
  } cfgst_state_t;

  // three scan inputs as seen at their pads
  typedef struct packed {
    logic tms;
    logic tck;
    logic tdi;
  } cfgst_scan_t;

  // open-drain pin seen from inside
  typedef struct packed {
    logic out;
    logic oe;
  } cfgst_pin_t;
endpackage

/* File: verilog/cfgst_regs.svh */
// timing constants and field positions for the configuration status pin logic
`ifndef CFGST_REGS_SVH
`define CFGST_REGS_SVH
`define CFGST_CLK_MHZ 25
`define CFGST_WAIT_MIN_US 30
`define CFGST_WAIT_MAX_US 300
// least and longest wait as exact cycle counts, no rounding
`define CFGST_WAIT_MIN_CYC (`CFGST_WAIT_MIN_US * `CFGST_CLK_MHZ)
`define CFGST_WAIT_MAX_CYC (`CFGST_WAIT_MAX_US * `CFGST_CLK_MHZ)
`define CFGST_CLEAR_CYC 64
`define CFGST_CNT_W 13
// scan pin vector positions
`define CFGST_SCAN_TDI 0
`define CFGST_SCAN_TCK 1
`define CFGST_SCAN_TMS 2
`endif

/* File: verilog/cfgst_top.sv */
// configuration status pins: busy outputs, init pin, scan pin gating
// ****************************************
// How it works
// - high busy output until user I/O active
// - low busy output until user I/O active
// - init held low during power and clearing
// - external init low keeps device waiting
// - master waits a fixed WAIT_CYC+1 cycles more, 751 cycles by default
// - init pulled low on data error
// - init released to user after start
// - no scan primitive: scan off, pins user
// - scan inputs taken straight from pads
// ****************************************
`timescale 1ns/1ps
`include "cfgst_regs.svh"
module cfgst_top #(
  parameter int CLEAR_CYC = `CFGST_CLEAR_CYC, // memory clear length
  parameter int WAIT_CYC = `CFGST_WAIT_MIN_CYC // extra master wait, 750 default
) (
  input wire logic clock_i, // config clock 25 MHz
  input wire logic rst_i, // power-on reset
  input wire logic master_mode_i, // device is config master
  input wire logic scan_keep_primitive_i, // design keeps scan primitive
  input wire logic data_error_i, // error seen in config stream
  input wire logic load_done_i, // stream fully loaded
  input wire logic init_in_i, // init pin level
  output logic init_out_o, // init pin output value
  output logic init_oe_o, // init pin driven low
  input wire logic user_init_out_i, // user drive for init pin
  input wire logic user_init_oe_i, // user enable for init pin
  input wire logic user_hi_out_i, // user value for high busy pin
  input wire logic user_lo_out_i, // user value for low busy pin
  output logic cfg_busy_high_out_o, // high while configuring
  output logic cfg_busy_low_out_o, // low while configuring
  input wire cfgst_pkg::cfgst_scan_t scan_pad_i, // scan inputs at pads
  output cfgst_pkg::cfgst_scan_t scan_core_o, // scan inputs to test logic
  output cfgst_pkg::cfgst_scan_t scan_user_o, // scan pins as user inputs
  output logic scan_enable_o, // scan functions enabled
  output logic load_enable_o, // config data may be taken
  output logic user_active_o // user I/O active
);
  import cfgst_pkg::*;

  // ****************************************
  // state
  // ****************************************
  // sequencer state and the clearing count
  cfgst_state_t state_r;
  cfgst_state_t state_nxt;
  logic [`CFGST_CNT_W-1:0] clr_cnt_r;
  logic delay_done;
  logic init_pin_low;
  logic clear_done;
  logic configuring;

  // pin reads low when driven or held outside
  assign init_pin_low = !init_in_i;
  assign clear_done = (clr_cnt_r == `CFGST_CNT_W'(CLEAR_CYC - 1));
  assign configuring = (state_r != CFGST_USER);

  // memory clearing counter
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clr_cnt_r <= '0;
    end else if (state_r == CFGST_CLEAR && !clear_done) begin
      clr_cnt_r <= clr_cnt_r + 1'b1;
    end
  end

  // extra wait for master devices after init rises
  cfgst_delay #(
    .CNT_W(`CFGST_CNT_W)
  ) u_delay (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(state_r != CFGST_DELAY),
    .run_i(state_r == CFGST_DELAY),
    .limit_i(`CFGST_CNT_W'(WAIT_CYC - 1)),
    .done_o(delay_done)
  );

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CFGST_POWER: begin
        state_nxt = CFGST_CLEAR;
      end
      CFGST_CLEAR: begin
        if (clear_done) begin
          state_nxt = CFGST_WAIT;
        end
      end
      CFGST_WAIT: begin
        // stay while anyone holds init low
        if (!init_pin_low) begin
          state_nxt = master_mode_i ? CFGST_DELAY : CFGST_LOAD;
        end
      end
      CFGST_DELAY: begin
        if (init_pin_low) begin
          state_nxt = CFGST_WAIT;
        end else if (delay_done) begin
          state_nxt = CFGST_LOAD;
        end
      end
      CFGST_LOAD: begin
        if (data_error_i) begin
          state_nxt = CFGST_ERROR;
        end else if (load_done_i) begin
          state_nxt = CFGST_USER;
        end
      end
      CFGST_ERROR: begin
        state_nxt = CFGST_ERROR; // held until power-on reset
      end
      CFGST_USER: begin
        state_nxt = CFGST_USER;
      end
      default: begin
        state_nxt = CFGST_POWER; // unused code restarts the start-up
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CFGST_POWER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // init pin
  // ****************************************
  // init value: always low while configuring, user value after start
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      init_out_o <= 1'b0;
    end else if (state_nxt == CFGST_USER) begin
      init_out_o <= user_init_out_i;
    end else begin
      init_out_o <= 1'b0;
    end
  end

  // init enable: pull low in power, clear and error; user owns it after start
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      init_oe_o <= 1'b1;
    end else if (state_nxt == CFGST_USER) begin
      init_oe_o <= user_init_oe_i;
    end else begin
      init_oe_o <= (state_nxt == CFGST_POWER) || (state_nxt == CFGST_CLEAR)
        || (state_nxt == CFGST_ERROR);
    end
  end

  // ****************************************
  // busy outputs
  // ****************************************
  // high busy pin: held high until user I/O go live
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_busy_high_out_o <= 1'b1;
    end else begin
      cfg_busy_high_out_o <= (state_nxt == CFGST_USER) ? user_hi_out_i : 1'b1;
    end
  end

  // low busy pin: held low until user I/O go live
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_busy_low_out_o <= 1'b0;
    end else begin
      cfg_busy_low_out_o <= (state_nxt == CFGST_USER) ? user_lo_out_i : 1'b0;
    end
  end

  // user I/O live flag, permanent once set
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      user_active_o <= 1'b0;
    end else begin
      user_active_o <= (state_nxt == CFGST_USER);
    end
  end

  // load window seen by the host side
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      load_enable_o <= 1'b0;
    end else begin
      load_enable_o <= (state_nxt == CFGST_LOAD);
    end
  end

  // ****************************************
  // scan pins
  // ****************************************
  // scan stays live during config and after if primitive kept
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scan_enable_o <= 1'b1;
    end else begin
      scan_enable_o <= configuring || scan_keep_primitive_i;
    end
  end

  // pad values registered once, no I/O block path
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scan_core_o <= '0;
    end else begin
      scan_core_o <= scan_pad_i;
    end
  end

  // pads reach user logic only after start without the primitive
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scan_user_o <= '0;
    end else begin
      scan_user_o <= (!configuring && !scan_keep_primitive_i) ? scan_pad_i : '0;
    end
  end
endmodule
